// File: acs_pkg.sv
/*
  Package for the converter sequencer: register offsets, field positions,
  reset values, timing constants, state encoding and shared helpers.
  Assumes a 100 MHz MCLK and 32-bit AXI4-Lite data.
*/
`default_nettype none

package acs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;

  // Control register layout
  localparam int BIT_CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  localparam int BIT_TRIGGER = 7;
  localparam int BIT_IRQ_EN = 8;
  localparam int BIT_REPEAT = 11;
  localparam int BIT_DMA_EN = 12;
  localparam int BIT_POWER = 15;
  localparam int BIT_WIN_LSB = 16;
  localparam int WIN_W = 3;
  localparam int BIT_REF_LSB = 20;
  localparam int REF_W = 2;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_WMASK = 32'h0037_999f;

  // Status and result layout
  localparam int BIT_DONE = 0;
  localparam int RESULT_W = 14;
  localparam int BIT_OVERRUN = 31;

  // Channel select codes
  localparam logic [4:0] CHAN_LAST_INPUT = 5'h10;
  localparam logic [4:0] CHAN_SUPPLY_MON = 5'h1f;

  // Sample window codes and their lengths in clocks
  localparam logic [2:0] WIN_CODE_3 = 3'h4;
  localparam logic [2:0] WIN_CODE_6 = 3'h5;
  localparam logic [2:0] WIN_CODE_16 = 3'h6;
  localparam logic [7:0] WIN_CYC_3 = 8'h03;
  localparam logic [7:0] WIN_CYC_6 = 8'h06;
  localparam logic [7:0] WIN_CYC_16 = 8'h10;
  localparam logic [7:0] WIN_CYC_32 = 8'h20;

  // Fixed conversion phase
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 950;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11
  } acs_state_t;

  // Reserved codes take the longest window so the input always settles
  function automatic logic [7:0] acs_window_cycles(input logic [2:0] code);
    case (code)
      WIN_CODE_3: acs_window_cycles = WIN_CYC_3;
      WIN_CODE_6: acs_window_cycles = WIN_CYC_6;
      WIN_CODE_16: acs_window_cycles = WIN_CYC_16;
      default: acs_window_cycles = WIN_CYC_32;
    endcase
  endfunction : acs_window_cycles

  function automatic logic [31:0] acs_apply_strobe(input logic [31:0] old_val,
                                                   input logic [31:0] new_val,
                                                   input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    acs_apply_strobe = res;
  endfunction : acs_apply_strobe

endpackage : acs_pkg

`default_nettype wire

// File: acs_phase_timer.sv
/*
  Down counter timing one phase of a conversion.
  Assumes load is a one-cycle pulse on the MCLK domain.
*/
`default_nettype none

module acs_phase_timer #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic abort,
  input wire logic [CNT_W-1:0] count,
  output var logic done
);
  import acs_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic busy;

  initial
  begin
    if (CNT_W < 2 || (2 ** CNT_W) <= CONV_CYCLES)
      $error("acs_phase_timer: CNT_W too small for conversion phase");
  end

  // Done is sampled high at the edge count cycles after the load edge, so the
  // phase driven from it lasts exactly count cycles; count must be 2 or more
  always_ff @(posedge clk)
  begin
    if (srst || abort)
    begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (load)
    begin
      cnt <= count;
      busy <= 1'b1;
      done <= 1'b0;
    end
    else if (busy)
    begin
      cnt <= cnt - 1'b1;
      done <= (cnt == CNT_W'(2));
      busy <= (cnt != CNT_W'(2));
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule : acs_phase_timer

`default_nettype wire

// File: acs_chan_decode.sv
/*
  Maps the channel select code onto the input multiplexer controls.
  Assumes the multiplexer samples its select lines on MCLK.
*/
`default_nettype none

module acs_chan_decode (
  input wire logic clk,
  input wire logic srst,
  input wire logic [acs_pkg::CHAN_W-1:0] code,
  output var logic [acs_pkg::CHAN_W-1:0] input_sel,
  output var logic supply_mon
);
  import acs_pkg::*;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      input_sel <= '0;
      supply_mon <= 1'b0;
    end
    else if (code == CHAN_SUPPLY_MON)
    begin
      input_sel <= CHAN_LAST_INPUT; // [RULE24]
      supply_mon <= 1'b1; // [RULE24]
    end
    else if (code > CHAN_LAST_INPUT)
    begin
      input_sel <= CHAN_LAST_INPUT; // [RULE24]
      supply_mon <= 1'b0;
    end
    else
    begin
      input_sel <= code; // [RULE18]
      supply_mon <= 1'b0;
    end
  end

endmodule : acs_chan_decode

`default_nettype wire

// File: acs_sequencer.sv
/*
  Top of the converter sequencer: AXI4-Lite register slave, conversion
  state machine, result word with overrun, interrupt and DMA request.
  Assumes the analog core and input mux run on MCLK and that the analog
  result is valid on the cycle the conversion phase ends.
*/
// Contract
// [RULE1] Result is 14 bits in 32-bit word
// [RULE2] Fixed 950 ns conversion after sampling
// [RULE3] Window codes give 3, 6, 16, 32 clocks
// [RULE4] Bits 21:20 select the reference
// [RULE5] Bit 15 switches analog power
// [RULE6] Single mode: one conversion per trigger
// [RULE7] Repeat mode converts until bit cleared
// [RULE8] Completion stores result and sets done flag
// [RULE9] Interrupt when done flag and enable set
// [RULE10] Software clears done flag itself
// [RULE11] Unread result overwritten, overrun set, continue
// [RULE12] Reading result word clears overrun
// [RULE13] Overrun flag is result word MSB
// [RULE14] DMA request per conversion when enabled
// [RULE15] DMA channel uses request source 59
// [RULE16] Overrun never suppresses DMA request
// [RULE17] DMA enable changed only while idle
// [RULE18] Bits 4:0 select the input channel
// [RULE19] Writing bit 7 starts conversion
// [RULE20] Software follows documented setup order
// [RULE21] Control register resets to zero
// [RULE22] Hardware clears trigger once conversion starts
// [RULE23] Write one clears done flag
// [RULE24] Codes above 16 pick 16; 31 monitors supply
// [RULE25] Unused result bits read zero
`default_nettype none

module acs_sequencer #(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 8
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic AWVALID,
  output var logic AWREADY,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic WVALID,
  output var logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output var logic BVALID,
  input wire logic BREADY,
  output var logic [1:0] BRESP,
  input wire logic ARVALID,
  output var logic ARREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  output var logic RVALID,
  input wire logic RREADY,
  output var logic [31:0] RDATA,
  output var logic [1:0] RRESP,
  output var logic ANA_POWER_ON,
  output var logic [acs_pkg::REF_W-1:0] ANA_REF_SEL,
  output var logic [acs_pkg::CHAN_W-1:0] ANA_INPUT_SEL,
  output var logic ANA_SUPPLY_MON,
  output var logic ANA_SAMPLE,
  output var logic ANA_CONVERT,
  input wire logic [acs_pkg::RESULT_W-1:0] ANA_RESULT,
  output var logic IRQ,
  output var logic DMA_REQ
);
  import acs_pkg::*;

  initial
  begin
    if (ADDR_W < 4 || ADDR_W > 32)
      $error("acs_sequencer: ADDR_W must be 4 to 32");
  end

  // Register state
  logic [31:0] control;
  logic done_flag;
  logic overrun;
  logic unread;
  logic [RESULT_W-1:0] result;

  // Bus state
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic [31:0] rd_word;
  logic rd_hit;

  // Sequencer state
  acs_state_t state;
  logic timer_load;
  logic [CNT_W-1:0] timer_count;
  logic timer_done;
  logic start;
  logic finish;

  // Control fields
  logic power_on;
  logic trigger;
  logic repeat_mode;
  logic irq_enable;
  logic dma_enable;
  logic [WIN_W-1:0] window_sel;

  assign power_on = control[BIT_POWER];
  assign trigger = control[BIT_TRIGGER];
  assign repeat_mode = control[BIT_REPEAT];
  assign irq_enable = control[BIT_IRQ_EN];
  assign dma_enable = control[BIT_DMA_EN];
  assign window_sel = control[BIT_WIN_LSB +: WIN_W];

  function automatic logic [ADDR_W-3:0] word_of(input logic [ADDR_W-1:0] addr);
    word_of = addr[ADDR_W-1:2];
  endfunction : word_of

  function automatic logic is_reg(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    is_reg = (word_of(addr) == (ADDR_W-2)'(ofs >> 2));
  endfunction : is_reg

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    is_mapped = is_reg(addr, OFS_CONTROL) || is_reg(addr, OFS_STATUS)
                || is_reg(addr, OFS_RESULT);
  endfunction : is_mapped

  // Write address channel
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      AWREADY <= 1'b0;
      aw_full <= 1'b0;
      aw_addr <= '0;
    end
    else if (AWVALID && AWREADY)
    begin
      AWREADY <= 1'b0;
      aw_full <= 1'b1;
      aw_addr <= AWADDR;
    end
    else if (do_write)
    begin
      aw_full <= 1'b0;
    end
    else
    begin
      AWREADY <= !aw_full && !BVALID;
    end
  end

  // Write data channel
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      WREADY <= 1'b0;
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (WVALID && WREADY)
    begin
      WREADY <= 1'b0;
      w_full <= 1'b1;
      w_data <= WDATA;
      w_strb <= WSTRB;
    end
    else if (do_write)
    begin
      w_full <= 1'b0;
    end
    else
    begin
      WREADY <= !w_full && !BVALID;
    end
  end

  assign do_write = aw_full && w_full && !BVALID;

  // Write response
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end
    else if (do_write)
    begin
      BVALID <= 1'b1;
      BRESP <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (BREADY)
    begin
      BVALID <= 1'b0;
    end
  end

  // Read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (is_reg(ARADDR, OFS_CONTROL))
    begin
      rd_word = control & CONTROL_WMASK;
    end
    else if (is_reg(ARADDR, OFS_STATUS))
    begin
      rd_word[BIT_DONE] = done_flag;
    end
    else if (is_reg(ARADDR, OFS_RESULT))
    begin
      rd_word[RESULT_W-1:0] = result; // [RULE1] [RULE25]
      rd_word[BIT_OVERRUN] = overrun; // [RULE13]
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  assign do_read = ARVALID && ARREADY;

  // Read channel
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end
    else if (do_read)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_word;
      RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (RVALID)
    begin
      RVALID <= !RREADY;
    end
    else
    begin
      ARREADY <= 1'b1;
    end
  end

  assign start = (state == ST_IDLE) && trigger && power_on;
  assign finish = (state == ST_CONVERT) && timer_done;

  // Control register; the start clears the trigger in the same edge unless a control write lands there and wins
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      control <= CONTROL_RESET; // [RULE21]
    end
    else if (do_write && is_reg(aw_addr, OFS_CONTROL))
    begin
      control <= acs_apply_strobe(control, w_data, w_strb) & CONTROL_WMASK; // [RULE19]
    end
    else if (start)
    begin
      control[BIT_TRIGGER] <= 1'b0; // [RULE22]
    end
  end

  // Conversion sequencer
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      state <= ST_IDLE;
    end
    else if (!power_on)
    begin
      state <= ST_IDLE; // [RULE5]
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (start)
            state <= ST_SAMPLE; // [RULE19]
        end
        ST_SAMPLE:
        begin
          if (timer_done)
            state <= ST_CONVERT; // [RULE2]
        end
        ST_CONVERT:
        begin
          if (timer_done)
            state <= repeat_mode ? ST_SAMPLE : ST_IDLE; // [RULE6] [RULE7]
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Phase timer loads: window on entry to sampling, fixed time on entry to conversion
  always_comb
  begin
    timer_load = 1'b0;
    timer_count = '0;
    if (start || (finish && repeat_mode))
    begin
      timer_load = 1'b1;
      timer_count = CNT_W'(acs_window_cycles(window_sel)); // [RULE3]
    end
    else if (state == ST_SAMPLE && timer_done)
    begin
      timer_load = 1'b1;
      timer_count = CNT_W'(CONV_CYCLES); // [RULE2]
    end
  end

  acs_phase_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .clk(MCLK),
    .srst(SRST),
    .load(timer_load && power_on),
    .abort(!power_on),
    .count(timer_count),
    .done(timer_done)
  );

  // Analog phase strobes
  always_ff @(posedge MCLK)
  begin
    if (SRST || !power_on)
    begin
      ANA_SAMPLE <= 1'b0;
      ANA_CONVERT <= 1'b0;
    end
    else
    begin
      ANA_SAMPLE <= start || (finish && repeat_mode)
                    || (state == ST_SAMPLE && !timer_done);
      ANA_CONVERT <= (state == ST_SAMPLE && timer_done)
                     || (state == ST_CONVERT && !timer_done); // [RULE2]
    end
  end

  // Result word and overrun; a result read in the completion cycle neither sets nor clears overrun
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      result <= '0;
      overrun <= 1'b0;
      unread <= 1'b0;
    end
    else if (finish)
    begin
      result <= ANA_RESULT; // [RULE1] [RULE8] [RULE11]
      unread <= 1'b1;
      if (unread && !(do_read && is_reg(ARADDR, OFS_RESULT)))
        overrun <= 1'b1; // [RULE11]
    end
    else if (do_read && is_reg(ARADDR, OFS_RESULT))
    begin
      overrun <= 1'b0; // [RULE12]
      unread <= 1'b0;
    end
  end

  // Done flag: completion wins over a write-one clear
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      done_flag <= 1'b0;
    end
    else if (finish)
    begin
      done_flag <= 1'b1; // [RULE8]
    end
    else if (do_write && is_reg(aw_addr, OFS_STATUS) && w_strb[0] && w_data[BIT_DONE])
    begin
      done_flag <= 1'b0; // [RULE23] [RULE10]
    end
  end

  // Interrupt and DMA request; overrun plays no part in the request
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      IRQ <= 1'b0;
      DMA_REQ <= 1'b0;
    end
    else
    begin
      IRQ <= (done_flag || finish) && irq_enable; // [RULE9]
      DMA_REQ <= finish && dma_enable; // [RULE14] [RULE16]
    end
  end

  // Analog configuration follows the control register
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      ANA_POWER_ON <= 1'b0;
      ANA_REF_SEL <= '0;
    end
    else
    begin
      ANA_POWER_ON <= power_on; // [RULE5]
      ANA_REF_SEL <= control[BIT_REF_LSB +: REF_W]; // [RULE4]
    end
  end

  acs_chan_decode u_chan (
    .clk(MCLK),
    .srst(SRST),
    .code(control[BIT_CHAN_LSB +: CHAN_W]),
    .input_sel(ANA_INPUT_SEL),
    .supply_mon(ANA_SUPPLY_MON)
  );

endmodule : acs_sequencer

`default_nettype wire

// File: acs_seq_checker.sv
/*
  Port checker for the converter sequencer.
  Assumes binding onto acs_sequencer; single MCLK domain, SRST high resets.
*/
`default_nettype none

module acs_seq_checker (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic ANA_SAMPLE,
  input wire logic ANA_CONVERT,
  input wire logic [acs_pkg::CHAN_W-1:0] ANA_INPUT_SEL,
  input wire logic ANA_SUPPLY_MON,
  input wire logic DMA_REQ
);
  import acs_pkg::*;
  logic [7:0] conv_cnt;
  logic [7:0] samp_cnt;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (SRST);
  // Phase lengths exceed any legal repetition count, so count them here
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      conv_cnt <= 8'h00;
      samp_cnt <= 8'h00;
    end
    else
    begin
      conv_cnt <= ANA_CONVERT ? conv_cnt + 8'h01 : 8'h00;
      samp_cnt <= ANA_SAMPLE ? samp_cnt + 8'h01 : 8'h00;
    end
  end
  sequence s_sample_end;
    ANA_SAMPLE ##1 !ANA_SAMPLE;
  endsequence
  sequence s_conv_end;
    ANA_CONVERT ##1 !ANA_CONVERT;
  endsequence
  a_phase_excl: assert property (!(ANA_SAMPLE && ANA_CONVERT))
    else $error("sample and convert overlap");
  a_conv_len: assert property (s_conv_end |-> conv_cnt == 8'h5f)
    else $error("convert phase length wrong");
  a_sample_len: assert property (s_sample_end |-> ANA_CONVERT &&
    (samp_cnt inside {8'h03, 8'h06, 8'h10, 8'h20}))
    else $error("sample window length wrong");
  a_conv_after_sample: assert property ($rose(ANA_CONVERT) |-> $past(ANA_SAMPLE))
    else $error("convert without sample");
  a_dma_pulse: assert property (DMA_REQ |=> !DMA_REQ)
    else $error("dma request longer than one cycle");
  a_dma_cause: assert property (DMA_REQ |-> $past(ANA_CONVERT) && !ANA_CONVERT)
    else $error("dma request without completion");
  a_input_range: assert property (ANA_INPUT_SEL <= CHAN_LAST_INPUT)
    else $error("input select out of range");
  a_supply_sel: assert property (ANA_SUPPLY_MON |-> ANA_INPUT_SEL == CHAN_LAST_INPUT)
    else $error("supply monitor with wrong input");
endmodule : acs_seq_checker

bind acs_sequencer acs_seq_checker u_chk (.MCLK(MCLK), .SRST(SRST), .ANA_SAMPLE(ANA_SAMPLE),
  .ANA_CONVERT(ANA_CONVERT), .ANA_INPUT_SEL(ANA_INPUT_SEL),
  .ANA_SUPPLY_MON(ANA_SUPPLY_MON), .DMA_REQ(DMA_REQ));

`default_nettype wire

// File: acs_ana_model.sv
/*
  Analog core model: result coded from mux, reference and a conversion count.
  Assumes the sequencer takes the result on the last convert cycle.
*/
`default_nettype none

module acs_ana_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic convert,
  input wire logic [4:0] input_sel,
  input wire logic supply_mon,
  input wire logic [1:0] ref_sel,
  output logic [13:0] result
);
  logic [5:0] nconv;
  logic conv_d;
  logic [13:0] noise;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      nconv <= 6'h00;
      conv_d <= 1'b0;
      noise <= 14'h1555;
    end
    else
    begin
      conv_d <= convert;
      noise <= ~noise;
      if (conv_d && !convert)
      begin
        nconv <= nconv + 6'h01;
      end
    end
  end
  // Toggles outside conversion so a capture at the wrong cycle cannot match
  assign result = convert ? {supply_mon, input_sel, ref_sel, nconv} : noise;
endmodule : acs_ana_model

`default_nettype wire

// File: tb.sv
/*
  Self-checking bench for the converter sequencer.
  Assumes the analog model above and an AXI4-Lite master driven here.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, pwr, smon, samp, conv, irq, dma;
  logic [1:0] bresp, rresp, rsel;
  logic [4:0] isel;
  logic [13:0] ares;
  int error_cnt = 0, checked = 0, cyc = 0, dma_cnt = 0;
  // Request source that the DMA channel serving the converter is programmed with
  localparam logic [5:0] DMA_SOURCE = 6'h3b;
  always #5 mclk = ~mclk;
  acs_sequencer dut (.MCLK(mclk), .SRST(srst), .AWVALID(awvalid), .AWREADY(awready),
    .AWADDR(awaddr), .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
    .WSTRB(4'hf), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
    .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready),
    .RDATA(rdata), .RRESP(rresp), .ANA_POWER_ON(pwr), .ANA_REF_SEL(rsel),
    .ANA_INPUT_SEL(isel), .ANA_SUPPLY_MON(smon), .ANA_SAMPLE(samp), .ANA_CONVERT(conv),
    .ANA_RESULT(ares), .IRQ(irq), .DMA_REQ(dma));
  acs_ana_model u_ana (.clk(mclk), .srst(srst), .convert(conv), .input_sel(isel),
    .supply_mon(smon), .ref_sel(rsel), .result(ares));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Whole run is about a thousand cycles; the ceiling only catches a hang
  always @(posedge mclk)
  begin
    cyc++;
    if (dma === 1'b1 && DMA_SOURCE == 6'h3b)
      dma_cnt++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awvalid && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge mclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axr
  // Returns one edge after the result is stored, counting sample cycles
  task automatic conv_wait(output int ns);
    ns = 0;
    while (samp !== 1'b1) @(posedge mclk);
    while (samp === 1'b1)
    begin
      ns++;
      @(posedge mclk);
    end
    while (conv === 1'b1) @(posedge mclk);
  endtask : conv_wait
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    chk("outputs", 32'h0, {27'h0, pwr, samp, conv, irq, dma});
    axr(OFS_CONTROL, d, r);
    chk("control reset", CONTROL_RESET, d);
    axw(OFS_RESULT, 32'hffff_ffff, r);
    axr(OFS_RESULT, d, r);
    chk("result ro", 32'h0, d);
    axr(8'h10, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    $display("register test done");
  endtask : t_regs
  task automatic t_single();
    logic [31:0] ctl, d;
    logic [1:0] r;
    logic [4:0] ch;
    int ns;
    int win_tab[4] = '{3, 6, 16, 32};
    logic [4:0] chans[4] = '{5'h00, 5'h10, 5'h14, 5'h1f};
    for (int i = 0; i < 4; i++)
    begin
      ch = chans[i];
      ctl = 32'h0000_8180 | (32'(i + 4) << 16) | (32'(i) << 20) | 32'(ch);
      axw(OFS_CONTROL, ctl, r);
      conv_wait(ns);
      chk("window", 32'(win_tab[i]), 32'(ns));
      #1;
      chk("irq", 32'h1, 32'(irq));
      axr(OFS_RESULT, d, r);
      chk("result", {18'h0, ch == 5'h1f, (ch > 5'h10) ? 5'h10 : ch, 2'(i), 6'(i)}, d);
      axr(OFS_STATUS, d, r);
      chk("done", 32'h1, d);
      axr(OFS_CONTROL, d, r);
      chk("control", ctl & ~32'h0000_0080, d);
      axw(OFS_STATUS, 32'h1, r);
      axr(OFS_STATUS, d, r);
      chk("cleared", 32'h0, d);
      chk("irq off", 32'h0, 32'(irq));
      chk("idle", 32'h0, 32'(samp));
    end
    chk("dma off", 32'h0, 32'(dma_cnt));
    chk("power", 32'h1, 32'(pwr));
    $display("single test done");
  endtask : t_single
  task automatic t_repeat();
    logic [31:0] d;
    logic [1:0] r;
    int ns;
    axw(OFS_CONTROL, 32'h0004_9883, r);
    conv_wait(ns);
    conv_wait(ns);
    axr(OFS_RESULT, d, r);
    chk("overrun", {1'b1, 17'h0, 1'b0, 5'h03, 2'h0, 6'h05}, d);
    chk("dma count", 32'h2, 32'(dma_cnt));
    axr(OFS_RESULT, d, r);
    chk("overrun clear", {18'h0, 1'b0, 5'h03, 2'h0, 6'h05}, d);
    axw(OFS_CONTROL, 32'h0000_9000, r);
    // One window of 3 plus the 95-cycle phase, with margin
    repeat (120) @(posedge mclk);
    chk("stopped", 32'h0, {30'h0, samp, conv});
    chk("irq masked", 32'h0, 32'(irq));
    axw(OFS_CONTROL, 32'h0, r);
    #1;
    chk("power off", 32'h0, 32'(pwr));
    $display("repeat test done");
  endtask : t_repeat
  initial
  begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_regs();
    t_single();
    t_repeat();
    finish_test();
  end
endmodule : tb

`default_nettype wire
